// *** hw/mbdsf_pkg.sv ***
package mbdsf_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] MBDSF_OFF_CTRL0 = 8'h76; // First pair control
   localparam logic [7:0] MBDSF_OFF_CTRL1 = 8'h77; // Second pair control
   localparam logic [7:0] MBDSF_CTRL_RESET = 8'h0c; // Fast off, no channel, pair off
   localparam logic [7:0] MBDSF_WMASK_ROUTE = 8'h8f; // Writable bits, routing variant
   localparam logic [7:0] MBDSF_WMASK_PLAIN = 8'h87; // Writable bits, bit 3 reserved
   localparam logic [7:0] MBDSF_RDATA_IDLE = 8'h00; // Read data outside a read answer

   // ----------------------------------------------------------------
   // Channel coding
   // ----------------------------------------------------------------
   localparam logic [2:0] MBDSF_CHAN_NONE = 3'h4; // Code that selects no channel
   localparam int MBDSF_NUM_PAIRS = 2; // Motherboard request/ack pairs
   localparam int MBDSF_NUM_CHANS = 8; // Compatible channel slots (4 is cascade)

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int MBDSF_CLK_PERIOD_NS = 25; // Bridge clock, 40 MHz
   localparam int MBDSF_SYSCLK_PERIOD_NS = 125; // ISA bus clock, 8 MHz
   localparam int MBDSF_SYSCLK_DIV = (MBDSF_SYSCLK_PERIOD_NS + MBDSF_CLK_PERIOD_NS - 1)
      / MBDSF_CLK_PERIOD_NS; // Bridge clocks per ISA clock
   localparam logic [3:0] MBDSF_FAST_SYSCLKS = 4'h3; // Type F cycle length
   localparam logic [3:0] MBDSF_COMPAT_SYSCLKS = 4'h8; // Compatible cycle length

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic fast; // Type F and buffer enable
      logic [2:0] reserved; // Always zero
      logic mb_channel_disable; // 1: slot pair serves the channel
      logic [2:0] channel_select; // Chosen compatible channel
   } mbdsf_ctrl_type;

   typedef enum logic [1:0] {
      MBDSF_IDLE = 2'b01, // No transfer cycle
      MBDSF_RUN = 2'b10 // Transfer cycle in progress
   } mbdsf_cyc_state_type;

endpackage : mbdsf_pkg

// *** hw/mbdsf_cycle_timer.sv ***
`timescale 1ns/1ps
module mbdsf_cycle_timer (
   input wire logic ref_clk, // Bridge clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic sys_en, // One-cycle ISA clock enable
   input wire logic start, // Transfer cycle request pulse
   input wire logic fast, // Channel runs type F cycles
   output logic busy // Transfer cycle in progress
);
   import mbdsf_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   mbdsf_cyc_state_type state_reg; // Cycle state
   logic [3:0] count_reg; // ISA clocks left in the cycle
   logic [3:0] ticks_reg; // ISA clocks seen, checked only
   logic [3:0] len_reg; // Length loaded, checked only

   // Cycle length chosen at start, held for the whole cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= MBDSF_IDLE;
         count_reg <= 4'h0;
         len_reg <= 4'h0;
      end else begin
         case (state_reg)
            MBDSF_IDLE: begin
               if (start) begin
                  // Type F cycle is three ISA clocks
                  count_reg <= fast ? MBDSF_FAST_SYSCLKS : MBDSF_COMPAT_SYSCLKS;
                  len_reg <= fast ? MBDSF_FAST_SYSCLKS : MBDSF_COMPAT_SYSCLKS;
                  state_reg <= MBDSF_RUN;
               end
            end
            MBDSF_RUN: begin
               // Starts during a cycle are ignored
               if (sys_en) begin
                  if (count_reg == 4'h1) begin
                     state_reg <= MBDSF_IDLE;
                  end
                  count_reg <= count_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= MBDSF_IDLE;
            end
         endcase
      end
   end

   // Busy straight from the state flop
   assign busy = (state_reg == MBDSF_RUN);

   // Tick counter for the length check
   always_ff @(posedge ref_clk) begin
      if (rst || (state_reg == MBDSF_IDLE)) begin
         ticks_reg <= 4'h0;
      end else if (sys_en) begin
         ticks_reg <= ticks_reg + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_cycle_len;
      @(posedge ref_clk) disable iff (rst)
      $fell(busy) |-> (ticks_reg == len_reg);
   endproperty
   a_cycle_len: assert property (p_cycle_len)
      else $error("transfer cycle length wrong");

   property p_fast_load;
      @(posedge ref_clk) disable iff (rst)
      (start && fast && !busy) |=> (busy && count_reg == MBDSF_FAST_SYSCLKS);
   endproperty
   a_fast_load: assert property (p_fast_load)
      else $error("type F cycle not three ISA clocks");

   c_fast_cycle: cover property (@(posedge ref_clk) disable iff (rst)
      $fell(busy) && len_reg == MBDSF_FAST_SYSCLKS);

endmodule : mbdsf_cycle_timer

// *** hw/mbdsf_steer_ctrl.sv ***
// What this block does
// - Two byte registers at consecutive offsets.
// - Reset value: fast off, no channel, disabled.
// - Fast mode runs three-ISA-clock type F cycles.
// - Bit 7 enables type F and buffer.
// - Channel codes 0-3, 5-7; 100 selects none.
// - Bit 3 clear routes pair to channel.
// - Bit 3 set: slot pair serves channel.
// - Routed channel masks slot request and ack.
// - Bit 3 set ignores pair, ack inactive.
// - Routed plus fast also enables type F.
// - Bit 3 and fast enable slot type F.
// - Non-routing variant: fast only, bit 3 reserved.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module mbdsf_steer_ctrl #(
   parameter bit ROUTING = 1'b1, // 1: routing variant, 0: fast-only variant
   parameter int SYSCLK_DIV = mbdsf_pkg::MBDSF_SYSCLK_DIV // Bridge clocks per ISA clock
) (
   input wire logic ref_clk, // Bridge clock, 40 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic [7:0] addr, // Register offset
   input wire logic [7:0] wdata, // Write data
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after strobe
   input wire logic [1:0] mb_dma_request, // Motherboard requests
   output logic [1:0] mb_dma_ack_n, // Motherboard acks, low active
   input wire logic [7:0] isa_dreq, // Slot requests per channel
   output logic [7:0] isa_dack_n, // Slot acks per channel, low active
   output logic [7:0] ctl_dreq, // Requests to the DMA controller
   input wire logic [7:0] ctl_dack_n, // Acks from the DMA controller
   output logic [7:0] fast_enable, // Type F and 4-byte buffer per channel
   input wire logic [7:0] xfer_start, // Controller starts a transfer cycle
   output logic [7:0] xfer_busy // Transfer cycle timing per channel
);
   import mbdsf_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   mbdsf_ctrl_type ctrl_reg [MBDSF_NUM_PAIRS]; // Control registers
   logic [7:0] wmask; // Writable bits for this variant
   logic [3:0] div_cnt_reg; // ISA clock divider
   logic sys_en_reg; // ISA clock enable pulse
   logic [7:0] ctl_dreq_next; // Steered requests
   logic [7:0] isa_dack_n_next; // Steered slot acks
   logic [1:0] mb_ack_n_next; // Steered motherboard acks
   logic [7:0] fast_next; // Per-channel fast enables
   logic [7:0] rdata_next; // Read answer

   // Bit 3 exists only when routing
   assign wmask = ROUTING ? MBDSF_WMASK_ROUTE : MBDSF_WMASK_PLAIN;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Pair owns its channel: routing, bit 3 clear, real channel
   function automatic logic pair_routed(input mbdsf_ctrl_type c);
      pair_routed = ROUTING && !c.mb_channel_disable
         && (c.channel_select != MBDSF_CHAN_NONE);
   endfunction : pair_routed

   // Fast applies to a real channel only
   function automatic logic pair_fast(input mbdsf_ctrl_type c);
      pair_fast = c.fast && (c.channel_select != MBDSF_CHAN_NONE);
   endfunction : pair_fast

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Writes store only writable bits; reserved stay zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int p = 0; p < MBDSF_NUM_PAIRS; p++) begin
            ctrl_reg[p] <= mbdsf_ctrl_type'(MBDSF_CTRL_RESET & wmask);
         end
      end else if (wr_en) begin
         if (addr == MBDSF_OFF_CTRL0) begin
            ctrl_reg[0] <= mbdsf_ctrl_type'(wdata & wmask);
         end
         if (addr == MBDSF_OFF_CTRL1) begin
            ctrl_reg[1] <= mbdsf_ctrl_type'(wdata & wmask);
         end
      end
   end

   // Read mux; unmapped offsets answer zero
   always_comb begin
      rdata_next = MBDSF_RDATA_IDLE;
      if (rd_en) begin
         case (addr)
            MBDSF_OFF_CTRL0: rdata_next = ctrl_reg[0];
            MBDSF_OFF_CTRL1: rdata_next = ctrl_reg[1];
            default: rdata_next = MBDSF_RDATA_IDLE;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= MBDSF_RDATA_IDLE;
      end else begin
         rdata <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // ISA clock enable
   // ----------------------------------------------------------------
   // One pulse every SYSCLK_DIV bridge clocks
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_cnt_reg <= 4'h0;
         sys_en_reg <= 1'b0;
      end else if (div_cnt_reg == 4'(SYSCLK_DIV - 1)) begin
         div_cnt_reg <= 4'h0;
         sys_en_reg <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 4'h1;
         sys_en_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Request / acknowledge steering
   // ----------------------------------------------------------------
   // Pair 0 is applied last so it wins a shared channel; sharing
   // is a software fault and the result is only kept deterministic.
   always_comb begin
      ctl_dreq_next = isa_dreq; // Slot pairs by default
      isa_dack_n_next = ctl_dack_n;
      mb_ack_n_next = 2'b11; // Motherboard acks idle
      fast_next = 8'h00;
      for (int p = MBDSF_NUM_PAIRS - 1; p >= 0; p--) begin
         if (pair_routed(ctrl_reg[p])) begin
            // Motherboard pair replaces the slot pair
            ctl_dreq_next[ctrl_reg[p].channel_select] = mb_dma_request[p];
            isa_dack_n_next[ctrl_reg[p].channel_select] = 1'b1;
            mb_ack_n_next[p] = ctl_dack_n[ctrl_reg[p].channel_select];
         end
         if (pair_fast(ctrl_reg[p])) begin
            // Routed or slot device alike
            fast_next[ctrl_reg[p].channel_select] = 1'b1;
         end
      end
   end

   // Steering outputs registered
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctl_dreq <= 8'h00;
         isa_dack_n <= 8'hff;
         mb_dma_ack_n <= 2'b11;
      end else begin
         ctl_dreq <= ctl_dreq_next;
         isa_dack_n <= isa_dack_n_next;
         mb_dma_ack_n <= mb_ack_n_next;
      end
   end

   // Fast enables registered
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fast_enable <= 8'h00;
      end else begin
         fast_enable <= fast_next;
      end
   end

   // ----------------------------------------------------------------
   // Transfer cycle timing per channel
   // ----------------------------------------------------------------
   for (genvar c = 0; c < MBDSF_NUM_CHANS; c++) begin : g_timer
      mbdsf_cycle_timer u_timer (
         .ref_clk(ref_clk),
         .rst(rst),
         .sys_en(sys_en_reg),
         .start(xfer_start[c]),
         .fast(fast_enable[c]),
         .busy(xfer_busy[c])
      );
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_reset_value;
      @(posedge ref_clk) rst |=> (ctrl_reg[0] == (MBDSF_CTRL_RESET & wmask))
         && (ctrl_reg[1] == (MBDSF_CTRL_RESET & wmask));
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("control reset value wrong");

   property p_readback;
      @(posedge ref_clk) disable iff (rst)
      (wr_en && addr == MBDSF_OFF_CTRL1) ##1 (rd_en && addr == MBDSF_OFF_CTRL1)
         |=> (rdata == (($past(wdata, 2)) & wmask));
   endproperty
   a_readback: assert property (p_readback)
      else $error("read back differs from written value");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (rst)
      1'b1 |-> ((rdata & ~wmask) == 8'h00);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");

   property p_fast_on;
      @(posedge ref_clk) disable iff (rst)
      pair_fast(ctrl_reg[0]) |=> fast_enable[$past(ctrl_reg[0].channel_select)];
   endproperty
   a_fast_on: assert property (p_fast_on)
      else $error("fast enable missing on selected channel");

   property p_none_code;
      @(posedge ref_clk) disable iff (rst)
      (ctrl_reg[0].channel_select == MBDSF_CHAN_NONE
         && ctrl_reg[1].channel_select == MBDSF_CHAN_NONE)
         |=> (fast_enable == 8'h00) && (ctl_dreq == $past(isa_dreq));
   endproperty
   a_none_code: assert property (p_none_code)
      else $error("code 100 selected a channel");

   property p_route_req;
      @(posedge ref_clk) disable iff (rst)
      pair_routed(ctrl_reg[0])
         |=> ctl_dreq[$past(ctrl_reg[0].channel_select)] == $past(mb_dma_request[0]);
   endproperty
   a_route_req: assert property (p_route_req)
      else $error("motherboard request not steered");

   property p_mask_slot;
      @(posedge ref_clk) disable iff (rst)
      pair_routed(ctrl_reg[1]) |=> isa_dack_n[$past(ctrl_reg[1].channel_select)];
   endproperty
   a_mask_slot: assert property (p_mask_slot)
      else $error("slot ack active on routed channel");

   property p_slot_path;
      @(posedge ref_clk) disable iff (rst)
      (!pair_routed(ctrl_reg[0]) && !pair_routed(ctrl_reg[1]))
         |=> (ctl_dreq == $past(isa_dreq)) && (isa_dack_n == $past(ctl_dack_n));
   endproperty
   a_slot_path: assert property (p_slot_path)
      else $error("slot pair not passed through");

   property p_mb_ignored;
      @(posedge ref_clk) disable iff (rst)
      ctrl_reg[0].mb_channel_disable |=> mb_dma_ack_n[0];
   endproperty
   a_mb_ignored: assert property (p_mb_ignored)
      else $error("motherboard ack active while disabled");

   // Routed pair sees the ack of its channel
   property p_route_ack;
      @(posedge ref_clk) disable iff (rst)
      (pair_routed(ctrl_reg[0]) && !ctl_dack_n[ctrl_reg[0].channel_select])
         |=> !mb_dma_ack_n[0];
   endproperty
   a_route_ack: assert property (p_route_ack)
      else $error("motherboard ack not steered");

   // Second pair steers too, unless pair 0 holds the same channel
   property p_route_req1;
      @(posedge ref_clk) disable iff (rst)
      (pair_routed(ctrl_reg[1]) && ctrl_reg[1].channel_select != ctrl_reg[0].channel_select)
         |=> ctl_dreq[$past(ctrl_reg[1].channel_select)] == $past(mb_dma_request[1]);
   endproperty
   a_route_req1: assert property (p_route_req1)
      else $error("second motherboard request not steered");

   // Slot ack held idle under the first pair as well
   property p_mask_slot0;
      @(posedge ref_clk) disable iff (rst)
      pair_routed(ctrl_reg[0]) |=> isa_dack_n[$past(ctrl_reg[0].channel_select)];
   endproperty
   a_mask_slot0: assert property (p_mask_slot0)
      else $error("slot ack active on first routed channel");

   // Second motherboard ack idle while its pair is disabled
   property p_mb_ignored1;
      @(posedge ref_clk) disable iff (rst)
      ctrl_reg[1].mb_channel_disable |=> mb_dma_ack_n[1];
   endproperty
   a_mb_ignored1: assert property (p_mb_ignored1)
      else $error("second motherboard ack active while disabled");

   // No fast bit anywhere means no fast channel
   property p_fast_off;
      @(posedge ref_clk) disable iff (rst)
      (!pair_fast(ctrl_reg[0]) && !pair_fast(ctrl_reg[1])) |=> (fast_enable == 8'h00);
   endproperty
   a_fast_off: assert property (p_fast_off)
      else $error("fast enable set with fast mode off");

   // Fast-only variant never steers a motherboard pair
   property p_plain_only;
      @(posedge ref_clk) disable iff (rst)
      (!ROUTING) |=> (mb_dma_ack_n == 2'b11) && (ctl_dreq == $past(isa_dreq));
   endproperty
   a_plain_only: assert property (p_plain_only)
      else $error("fast-only variant steered a pair");

   // Read data fall back to idle outside a read answer
   property p_rdata_idle;
      @(posedge ref_clk) disable iff (rst)
      !rd_en |=> (rdata == MBDSF_RDATA_IDLE);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside a read answer");

   c_route_fast: cover property (@(posedge ref_clk) disable iff (rst)
      pair_routed(ctrl_reg[0]) && ctrl_reg[0].fast && !mb_dma_ack_n[0]);
   c_slot_fast: cover property (@(posedge ref_clk) disable iff (rst)
      ctrl_reg[1].mb_channel_disable && pair_fast(ctrl_reg[1]));
   c_both_routed: cover property (@(posedge ref_clk) disable iff (rst)
      pair_routed(ctrl_reg[0]) && pair_routed(ctrl_reg[1]));

endmodule : mbdsf_steer_ctrl

// *** tb/mbdsf_dev_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Requesting peripherals: two motherboard lines then eight slot lines
// ----------------------------------------------------------------
module mbdsf_dev_model (
   input wire logic ref_clk, // Bridge clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic slow, // 1: drop request late after ack
   input wire logic [9:0] go, // One-cycle pulse raises a request
   input wire logic [9:0] ack_n, // Acks seen by each requester
   output logic [9:0] req // Request levels toward the block
);
   logic [1:0] dly_reg [10]; // Cycles left before the request drops

   // Hold each request until its ack, like a real peripheral
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 10; i++) begin
         if (rst) begin
            req[i] <= 1'b0;
            dly_reg[i] <= 2'd0;
         end else if (go[i]) begin // New request
            req[i] <= 1'b1;
            dly_reg[i] <= slow ? 2'd3 : 2'd0;
         end else if (req[i] && !ack_n[i]) begin // Served: drop, maybe late
            if (dly_reg[i] == 2'd0) begin
               req[i] <= 1'b0;
            end else begin
               dly_reg[i] <= dly_reg[i] - 2'd1;
            end
         end
      end
   end
endmodule : mbdsf_dev_model

// *** tb/mbdsf_steer_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mbdsf_steer_ctrl_tb;
   import mbdsf_pkg::*;
   localparam int DIV = 2; // Short ISA clock divider for simulation
   logic ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, slow = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rdata_b;
   logic [7:0] ctl_dack_n = 8'hff, xfer_start = 8'h00, isa_dack_n, isa_dack_n_b;
   logic [7:0] ctl_dreq, ctl_dreq_b, fast_enable, fast_enable_b, xfer_busy;
   logic [1:0] mb_dma_ack_n, mb_dma_ack_n_b;
   logic [9:0] go = 10'h000, req;
   int fails = 0, checked = 0, cnt;

   // ----------------------------------------------------------------
   // Clock, devices under test and partner
   // ----------------------------------------------------------------
   always #12.5 ref_clk = ~ref_clk;
   mbdsf_steer_ctrl #(.ROUTING(1'b1), .SYSCLK_DIV(DIV)) i_mbdsf_steer_ctrl (
      .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .mb_dma_request(req[1:0]),
      .mb_dma_ack_n(mb_dma_ack_n), .isa_dreq(req[9:2]), .isa_dack_n(isa_dack_n),
      .ctl_dreq(ctl_dreq), .ctl_dack_n(ctl_dack_n), .fast_enable(fast_enable),
      .xfer_start(xfer_start), .xfer_busy(xfer_busy));
   // Fast-only variant shares every input; timer outputs left unused
   mbdsf_steer_ctrl #(.ROUTING(1'b0), .SYSCLK_DIV(DIV)) i_mbdsf_steer_ctrl_b (
      .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata_b), .mb_dma_request(req[1:0]),
      .mb_dma_ack_n(mb_dma_ack_n_b), .isa_dreq(req[9:2]), .isa_dack_n(isa_dack_n_b),
      .ctl_dreq(ctl_dreq_b), .ctl_dack_n(ctl_dack_n), .fast_enable(fast_enable_b),
      .xfer_start(xfer_start), .xfer_busy());
   // Slot requesters only see acks of the routing instance
   mbdsf_dev_model i_mbdsf_dev_model (.ref_clk(ref_clk), .rst(rst), .slow(slow),
      .go(go), .ack_n({isa_dack_n, mb_dma_ack_n}), .req(req));

   // ----------------------------------------------------------------
   // Bus and helper tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] eb);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      `CHK(rdata, e)
      `CHK(rdata_b, eb)
      @(posedge ref_clk);
      #1;
      `CHK(rdata, 8'h00)
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : idle

   task automatic raise(input int i);
      @(posedge ref_clk);
      go[i] <= 1'b1;
      @(posedge ref_clk);
      go[i] <= 1'b0;
   endtask : raise

   // Busy length of one transfer cycle must fall within lo..hi clocks
   task automatic timed(input int c, input int lo, input int hi);
      @(posedge ref_clk);
      xfer_start[c] <= 1'b1;
      @(posedge ref_clk);
      xfer_start[c] <= 1'b0;
      cnt = 0;
      #1;
      while (xfer_busy[c] === 1'b1 && cnt < 100) begin
         cnt++;
         idle(1);
      end
      `CHK(cnt >= lo && cnt <= hi, 1'b1)
   endtask : timed

   task automatic final_report;
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // Watchdog: all tests need well under two thousand clocks
   initial begin
      #(MBDSF_CLK_PERIOD_NS * 5000);
      fails++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      idle(2);
      // Reset state of registers and pins
      rd(MBDSF_OFF_CTRL0, 8'h0c, 8'h04);
      rd(MBDSF_OFF_CTRL1, 8'h0c, 8'h04);
      `CHK({mb_dma_ack_n, isa_dack_n, ctl_dreq, fast_enable}, 26'h3ff_0000)
      // Reserved bits dropped, unmapped place ignored
      wr(8'h76, 8'hff);
      wr(8'h78, 8'hff);
      rd(8'h76, 8'h8f, 8'h87);
      rd(8'h78, 8'h00, 8'h00);
      // Pairs on different channels: pair 0 to ch 2, pair 1 to ch 5
      wr(8'h76, 8'h02);
      wr(8'h77, 8'h05);
      raise(0);
      raise(4);
      idle(3);
      `CHK(ctl_dreq, 8'h04)
      `CHK(fast_enable, 8'h00)
      `CHK(ctl_dreq_b, 8'h04)
      @(posedge ref_clk) ctl_dack_n <= 8'hdb;
      idle(3);
      `CHK(mb_dma_ack_n, 2'b00)
      `CHK(isa_dack_n_b, 8'hdb)
      `CHK(isa_dack_n[2], 1'b1)
      `CHK(mb_dma_ack_n_b, 2'b11)
      `CHK(ctl_dreq[2], 1'b0)
      @(posedge ref_clk) ctl_dack_n <= 8'hff;
      // Slot pair serves ch 2, fast on; motherboard pair ignored
      wr(8'h76, 8'h8a);
      slow <= 1'b1;
      raise(0);
      idle(3);
      `CHK(ctl_dreq[2], 1'b1)
      `CHK(fast_enable, 8'h04)
      `CHK(fast_enable_b, 8'h04)
      @(posedge ref_clk) ctl_dack_n <= 8'hfb;
      idle(3);
      `CHK(mb_dma_ack_n[0], 1'b1)
      `CHK(isa_dack_n[2], 1'b0)
      idle(4);
      @(posedge ref_clk) ctl_dack_n <= 8'hff;
      idle(3);
      `CHK(ctl_dreq[2], 1'b0)
      // Routed and fast: waiting motherboard request reaches ch 2
      wr(8'h76, 8'h82);
      idle(3);
      `CHK(ctl_dreq[2], 1'b1)
      `CHK(fast_enable, 8'h04)
      @(posedge ref_clk) ctl_dack_n <= 8'hfb;
      idle(5);
      `CHK(mb_dma_ack_n[0], 1'b0)
      `CHK(ctl_dreq[2], 1'b1)
      idle(1);
      `CHK(ctl_dreq[2], 1'b0)
      @(posedge ref_clk) ctl_dack_n <= 8'hff;
      slow <= 1'b0;
      // Every channel code with fast on, slot pair mode
      wr(8'h76, 8'h0c);
      for (int c = 0; c < 8; c++) begin
         wr(8'h77, 8'h88 | 8'(c));
         idle(3);
         `CHK(fast_enable, (c == 4) ? 8'h00 : 8'(1 << c))
         `CHK(fast_enable_b, (c == 4) ? 8'h00 : 8'(1 << c))
      end
      wr(8'h77, 8'h09);
      idle(3);
      `CHK(fast_enable, 8'h00)
      // Type F cycle on ch 1, compatible cycle on ch 0
      // Write then read with no gap; reserved bits come back clear
      @(posedge ref_clk);
      addr <= MBDSF_OFF_CTRL1;
      wdata <= 8'hf9;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      `CHK(rdata, 8'h89)
      `CHK(rdata_b, 8'h81)
      idle(2);
      timed(1, 2 * DIV, 3 * DIV + 1);
      timed(0, 7 * DIV, 8 * DIV + 1);
      final_report();
   end
endmodule : mbdsf_steer_ctrl_tb
